// File: shared/xip_pkg.sv
/*
  Constants and types for the extra external interrupt channels and the
  auxiliary 4-bit port. Assumes an 8-bit special-function register bus.
*/
package xip_pkg;

  localparam int          XIP_AW          = 8;
  localparam int          XIP_DW          = 8;
  localparam int          XIP_PORT_W      = 4;
  localparam int          XIP_NSRC        = 8;
  localparam int          XIP_NSTD        = 6;

  // Register addresses, also the base bit addresses
  localparam logic [7:0]  XIP_CTRL_ADDR   = 8'hc0;
  localparam logic [7:0]  XIP_PORT_ADDR   = 8'hd8;
  localparam logic [4:0]  XIP_BASE_MASK   = 5'h1f;
  localparam logic [2:0]  XIP_BIT_SEL_W   = 3'h3;

  // Reset values
  localparam logic [7:0]  XIP_CTRL_RESET  = 8'h00;
  localparam logic [3:0]  XIP_PORT_RESET  = 4'hf;
  localparam logic [7:0]  XIP_READ_ZERO   = 8'h00;

  // Port pins that carry the interrupt inputs
  localparam int          XIP_PIN_CHAN_A  = 3;
  localparam int          XIP_PIN_CHAN_B  = 2;

  // Source indices in polling order, 0 is polled first
  localparam int          XIP_SRC_CHAN_A  = 6;
  localparam int          XIP_SRC_CHAN_B  = 7;

  // Vector addresses by polling position
  localparam logic [7:0]  XIP_VEC [XIP_NSRC] = '{
    8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33, 8'h3b
  };
  localparam logic [7:0]  XIP_VEC_NONE    = 8'h00;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic b_priority;
    logic b_enable;
    logic b_flag;
    logic b_trigger_type;
    logic a_priority;
    logic a_enable;
    logic a_flag;
    logic a_trigger_type;
  } xip_ctrl_t;

  // Request presented to the core interrupt sequencer
  typedef struct packed {
    logic       pending;
    logic       high;
    logic [2:0] source;
    logic [7:0] vector;
  } xip_irq_t;

endpackage

// File: hdl/xip_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous pin inputs.
  Assumes inputs are quasi-static relative to clk; no bus coherence implied.
*/
`timescale 1ns/1ps
module xip_sync #(
  parameter int W     = 4,
  parameter logic [W-1:0] INIT = '1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q   <= INIT;
      sync_out <= INIT;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: hdl/xip_top.sv
/*
  Extra external interrupt channels A and B with their control register,
  an eight-source priority/polling selector, and the 4-bit auxiliary port.
  Assumes the core drives a byte and bit special-function register bus on
  clk and acknowledges taken interrupts with the vector it jumps to.
*/
// Behaviour
// - Control register at address 0C0H, every bit settable singly by bit ops; in level mode the flag bits follow the pin instead.
// - Fields high to low: B prio, en, flag, trig; then A prio, en, flag, trig.
// - Priority bit 1 makes channel high priority, 0 low.
// - Request reaches core only while channel enable is 1.
// - Trigger 1 detects falling edge; trigger 0 treats low level as request.
// - Edge mode sets flag on edge, clears it when core vectors there.
// - Standard sources vector 03H..2BH, polled 0 to 5 within a level.
// - Channel A vectors to 33H, polled at position 6.
// - Channel B vectors to 3BH, polled last at position 7.
// - Auxiliary port at 0D8H, bit-addressable, low 4 bits, pulled-up bidirectional.
// - Port bits 3 and 2 serve as I/O and as channel inputs together.
// - Port write drives pins; port read returns pin status.
// - Reset loads 4-bit port latch with 0FH, control register with 00H.
`timescale 1ns/1ps
module xip_top
  import xip_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // Byte access
  input  wire logic [xip_pkg::XIP_AW-1:0]  sfr_addr,
  input  wire logic                        sfr_wr,
  input  wire logic                        sfr_rd,
  input  wire logic [xip_pkg::XIP_DW-1:0]  sfr_wdata,
  output logic      [xip_pkg::XIP_DW-1:0]  sfr_rdata,
  // Bit access
  input  wire logic [xip_pkg::XIP_AW-1:0]  bit_addr,
  input  wire logic                        bit_wr,
  input  wire logic                        bit_rd,
  input  wire logic                        bit_wdata,
  output logic                             bit_rdata,
  // Core interrupt sequencer
  input  wire logic [xip_pkg::XIP_NSTD-1:0] std_req,
  input  wire logic [xip_pkg::XIP_NSTD-1:0] std_high,
  input  wire logic                        irq_ack,
  input  wire logic [7:0]                  irq_ack_vector,
  output xip_pkg::xip_irq_t                irq_out,
  // Auxiliary port pins
  input  wire logic [xip_pkg::XIP_PORT_W-1:0] port_pin_in,
  output logic      [xip_pkg::XIP_PORT_W-1:0] port_pin_out,
  output logic      [xip_pkg::XIP_PORT_W-1:0] port_pin_oe
);

  xip_ctrl_t              ctrl_q;
  logic [XIP_PORT_W-1:0]  port_q;
  logic [XIP_PORT_W-1:0]  pin_s;
  logic                   pin_a_q;
  logic                   pin_b_q;
  logic                   fall_a;
  logic                   fall_b;
  logic                   ctrl_byte_wr;
  logic                   port_byte_wr;
  logic                   ctrl_bit_wr;
  logic                   port_bit_wr;
  logic [2:0]             bit_sel;
  logic [XIP_DW-1:0]      ctrl_bit_d;
  logic [XIP_PORT_W-1:0]  port_bit_d;
  logic                   ack_a;
  logic                   ack_b;
  logic [XIP_NSRC-1:0]    all_req;
  logic [XIP_NSRC-1:0]    all_high;
  xip_irq_t               irq_d;
  xip_ctrl_t              wdata_ctrl;

  // Pin inputs cross into clk before use
  xip_sync #(.W(XIP_PORT_W), .INIT(XIP_PORT_RESET)) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (port_pin_in),
    .sync_out (pin_s)
  );

  // Address decode for byte and bit access
  assign bit_sel      = bit_addr[2:0];
  assign ctrl_byte_wr = sfr_wr && (sfr_addr == XIP_CTRL_ADDR);
  assign port_byte_wr = sfr_wr && (sfr_addr == XIP_PORT_ADDR);
  assign ctrl_bit_wr  = bit_wr && (bit_addr[7:3] == XIP_CTRL_ADDR[7:3]);
  assign port_bit_wr  = bit_wr && (bit_addr[7:3] == XIP_PORT_ADDR[7:3])
                        && (bit_sel <= XIP_BIT_SEL_W);

  always_comb begin
    ctrl_bit_d          = ctrl_q;
    ctrl_bit_d[bit_sel] = bit_wdata;
    port_bit_d          = port_q;
    if (bit_sel <= XIP_BIT_SEL_W) begin
      port_bit_d[bit_sel[1:0]] = bit_wdata;
    end
  end

  // Falling edges on the shared port pins
  assign fall_a = pin_a_q && !pin_s[XIP_PIN_CHAN_A];
  assign fall_b = pin_b_q && !pin_s[XIP_PIN_CHAN_B];
  assign ack_a  = irq_ack && (irq_ack_vector == XIP_VEC[XIP_SRC_CHAN_A]);
  assign ack_b  = irq_ack && (irq_ack_vector == XIP_VEC[XIP_SRC_CHAN_B]);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_a_q <= 1'b1;
      pin_b_q <= 1'b1;
    end else begin
      pin_a_q <= pin_s[XIP_PIN_CHAN_A];
      pin_b_q <= pin_s[XIP_PIN_CHAN_B];
    end
  end

  // Control register: software fields, hardware-managed flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= xip_ctrl_t'(XIP_CTRL_RESET);
    end else begin
      if (ctrl_byte_wr) begin
        ctrl_q <= xip_ctrl_t'(sfr_wdata);
      end else if (ctrl_bit_wr) begin
        ctrl_q <= xip_ctrl_t'(ctrl_bit_d);
      end
      // Channel A and B flags: edge latches, level follows the pin
      if (!ctrl_q.a_trigger_type) begin
        ctrl_q.a_flag <= !pin_s[XIP_PIN_CHAN_A];
      end else if (fall_a) begin
        ctrl_q.a_flag <= 1'b1;
      end else if (ack_a) begin
        ctrl_q.a_flag <= 1'b0;
      end
      if (!ctrl_q.b_trigger_type) begin
        ctrl_q.b_flag <= !pin_s[XIP_PIN_CHAN_B];
      end else if (fall_b) begin
        ctrl_q.b_flag <= 1'b1;
      end else if (ack_b) begin
        ctrl_q.b_flag <= 1'b0;
      end
    end
  end

  // Port latch and quasi-bidirectional drive: pull low on 0, release on 1
  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_q       <= XIP_PORT_RESET;
      port_pin_out <= XIP_PORT_RESET;
      port_pin_oe  <= ~XIP_PORT_RESET;
    end else begin
      if (port_byte_wr) begin
        port_q       <= sfr_wdata[XIP_PORT_W-1:0];
        port_pin_out <= sfr_wdata[XIP_PORT_W-1:0];
        port_pin_oe  <= ~sfr_wdata[XIP_PORT_W-1:0];
      end else if (port_bit_wr) begin
        port_q       <= port_bit_d;
        port_pin_out <= port_bit_d;
        port_pin_oe  <= ~port_bit_d;
      end
    end
  end

  // Read data, one cycle after the strobe; port reads the pins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sfr_rdata <= XIP_READ_ZERO;
      bit_rdata <= 1'b0;
    end else begin
      if (sfr_rd) begin
        if (sfr_addr == XIP_CTRL_ADDR) begin
          sfr_rdata <= ctrl_q;
        end else if (sfr_addr == XIP_PORT_ADDR) begin
          sfr_rdata <= {{(XIP_DW-XIP_PORT_W){1'b0}}, pin_s};
        end else begin
          sfr_rdata <= XIP_READ_ZERO;
        end
      end
      if (bit_rd) begin
        if (bit_addr[7:3] == XIP_CTRL_ADDR[7:3]) begin
          bit_rdata <= ctrl_q[bit_sel];
        end else if ((bit_addr[7:3] == XIP_PORT_ADDR[7:3]) && (bit_sel <= XIP_BIT_SEL_W)) begin
          bit_rdata <= pin_s[bit_sel[1:0]];
        end else begin
          bit_rdata <= 1'b0;
        end
      end
    end
  end

  // Eight-source selection: high level first, then polling order
  assign all_req  = {ctrl_q.b_flag && ctrl_q.b_enable,
                     ctrl_q.a_flag && ctrl_q.a_enable, std_req};
  assign all_high = {ctrl_q.b_priority, ctrl_q.a_priority, std_high};

  always_comb begin
    irq_d = '0;
    irq_d.vector = XIP_VEC_NONE;
    for (int i = XIP_NSRC - 1; i >= 0; i--) begin
      if (all_req[i] && !all_high[i] && !(|(all_req & all_high))) begin
        irq_d.pending = 1'b1;
        irq_d.high    = 1'b0;
        irq_d.source  = 3'(i);
        irq_d.vector  = XIP_VEC[i];
      end
    end
    for (int i = XIP_NSRC - 1; i >= 0; i--) begin
      if (all_req[i] && all_high[i]) begin
        irq_d.pending = 1'b1;
        irq_d.high    = 1'b1;
        irq_d.source  = 3'(i);
        irq_d.vector  = XIP_VEC[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_out <= '0;
    end else begin
      irq_out <= irq_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Byte write data viewed as control fields
  assign wdata_ctrl = xip_ctrl_t'(sfr_wdata);

  ctrl_addr_wr_a: assert property (ctrl_byte_wr
    |=> ctrl_q.a_enable == $past(wdata_ctrl.a_enable)
    && ctrl_q.b_trigger_type == $past(wdata_ctrl.b_trigger_type))
    else $error("control byte write lost enable A or trigger B");
  enable_gate_a: assert property (!ctrl_q.a_enable && !ctrl_q.b_enable
    && !(|std_req) |=> !irq_out.pending)
    else $error("request passed with enables clear");
  edge_set_a: assert property (ctrl_q.a_trigger_type && fall_a
    && !ctrl_byte_wr && !ctrl_bit_wr |=> ctrl_q.a_flag)
    else $error("edge did not set flag A");
  edge_clear_a: assert property (ctrl_q.b_trigger_type && ack_b && !fall_b
    && !ctrl_byte_wr && !ctrl_bit_wr |=> !ctrl_q.b_flag)
    else $error("vector did not clear flag B");
  level_follow_a: assert property (!ctrl_q.a_trigger_type && !ctrl_byte_wr
    && !ctrl_bit_wr |=> ctrl_q.a_flag == !$past(pin_s[XIP_PIN_CHAN_A]))
    else $error("level flag A does not follow pin");
  vector_a_a: assert property (irq_out.pending
    && irq_out.source == 3'(XIP_SRC_CHAN_A) |-> irq_out.vector == 8'h33)
    else $error("channel A vector wrong");
  vector_b_a: assert property (all_req == 8'h80 && !ctrl_byte_wr
    |=> irq_out.vector == 8'h3b)
    else $error("channel B vector wrong");
  poll_order_a: assert property (all_req[0] && !(|all_high)
    |=> irq_out.source == 3'h0 && irq_out.vector == 8'h03)
    else $error("standard source 0 not polled first");
  high_wins_a: assert property (all_req[XIP_SRC_CHAN_B] && all_high[XIP_SRC_CHAN_B]
    && !(|(all_req[6:0] & all_high[6:0])) |=> irq_out.high
    && irq_out.vector == 8'h3b)
    else $error("high priority channel B did not win");
  port_drive_a: assert property (port_byte_wr
    |=> port_pin_out == $past(sfr_wdata[3:0]) && port_pin_oe == ~port_pin_out)
    else $error("port write not driven to pins");
  reset_vals_a: assert property (disable iff (1'b0) $rose(resetn)
    |-> port_q == 4'hf && ctrl_q == 8'h00)
    else $error("reset values wrong");

endmodule

// File: test/xip_far.sv
/*
  Far side model: pulled-up port pins and the core's interrupt acknowledge.
  Assumes xip_top on the same clk; ext_low lets the bench pull a pin down.
*/
`timescale 1ns/1ps
module xip_far
  import xip_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Pins
  input  wire logic [3:0]        pin_oe,
  input  wire logic [3:0]        ext_low,
  output logic      [3:0]        pin_in,
  // Core
  input  wire xip_pkg::xip_irq_t irq,
  input  wire logic              ack_en,
  output logic                   ack,
  output logic      [7:0]        ack_vec
);
  logic [2:0] hold_q;
  // Pull-up wins unless either side pulls low
  assign pin_in = ~(pin_oe | ext_low);
  initial begin
    ack = 1'b0;
    ack_vec = 8'h00;
    hold_q = 3'h0;
  end
  // Vector once, then back off while the flag clears
  always @(posedge clk) begin
    ack <= 1'b0;
    if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end else if (ack_en && irq.pending) begin
      ack <= 1'b1;
      ack_vec <= irq.vector;
      hold_q <= 3'h5;
    end
  end
endmodule

// File: test/tb.sv
/*
  Self-checking bench for xip_top: register tasks, pin and vector checks.
  Assumes the far side model xip_far and the package xip_pkg.
*/
`timescale 1ns/1ps
module tb;
  import xip_pkg::*;
  logic       clk, resetn, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, bit_rdata;
  logic       ack_en, irq_ack;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, irq_ack_vector;
  logic [5:0] std_req, std_high;
  logic [3:0] pin_in, pin_out, pin_oe, ext_low;
  xip_irq_t   irq_out;
  int         num_errors, n_compared;

  xip_top DUT (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr),
    .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata),
    .std_req(std_req), .std_high(std_high), .irq_ack(irq_ack),
    .irq_ack_vector(irq_ack_vector), .irq_out(irq_out), .port_pin_in(pin_in),
    .port_pin_out(pin_out), .port_pin_oe(pin_oe));
  xip_far far (.clk(clk), .pin_oe(pin_oe), .ext_low(ext_low), .pin_in(pin_in),
    .irq(irq_out), .ack_en(ack_en), .ack(irq_ack), .ack_vec(irq_ack_vector));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 chk(13'(sfr_rdata), 13'(e));
  endtask
  task automatic bwr(input logic [7:0] a, input logic v);
    @(posedge clk);
    bit_wr <= 1'b1;
    bit_addr <= a;
    bit_wdata <= v;
    @(posedge clk);
    bit_wr <= 1'b0;
  endtask
  task automatic brd(input logic [7:0] a, input logic e);
    @(posedge clk);
    bit_rd <= 1'b1;
    bit_addr <= a;
    @(posedge clk);
    bit_rd <= 1'b0;
    #1 chk(13'(bit_rdata), 13'(e));
  endtask
  task automatic fall(input int p);
    @(posedge clk);
    ext_low[p] <= 1'b1;
    repeat (3) @(posedge clk);
    ext_low[p] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic irq_is(input logic [12:0] e);
    repeat (6) @(posedge clk);
    #1 chk(irq_out, e);
  endtask
  function automatic logic [12:0] req(input logic h, input int s);
    return {1'b1, h, s[2:0], XIP_VEC[s]};
  endfunction
  task automatic wrap_up;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    {resetn, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, ack_en} = '0;
    {sfr_addr, sfr_wdata, bit_addr, std_req, std_high, ext_low} = '0;
    num_errors = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd(XIP_CTRL_ADDR, 8'h00);
    rd(XIP_PORT_ADDR, 8'h0f);
    chk(13'(pin_out), 13'h000f);
    rd(8'h55, 8'h00);
    $display("test reset done");
    wr(XIP_PORT_ADDR, 8'h0a);
    chk(13'(pin_out), 13'h000a);
    chk(13'(pin_oe), 13'h0005);
    repeat (3) @(posedge clk);
    rd(XIP_PORT_ADDR, 8'h0a);
    brd(8'hdb, 1'b1);
    brd(8'hda, 1'b0);
    rd(XIP_CTRL_ADDR, 8'h20);
    chk(irq_out, 13'h0000);
    bwr(8'hd8, 1'b1);
    repeat (3) @(posedge clk);
    rd(XIP_PORT_ADDR, 8'h0b);
    wr(XIP_PORT_ADDR, 8'h0f);
    repeat (4) @(posedge clk);
    rd(XIP_CTRL_ADDR, 8'h00);
    $display("test port done");
    bwr(8'hc2, 1'b1);
    rd(XIP_CTRL_ADDR, 8'h04);
    bwr(8'hc7, 1'b1);
    rd(XIP_CTRL_ADDR, 8'h84);
    wr(XIP_CTRL_ADDR, 8'h05);
    fall(XIP_PIN_CHAN_A);
    rd(XIP_CTRL_ADDR, 8'h07);
    chk(irq_out, req(1'b0, 6));
    wr(XIP_CTRL_ADDR, 8'h0f);
    irq_is(req(1'b1, 6));
    @(posedge clk);
    ack_en <= 1'b1;
    repeat (8) @(posedge clk);
    rd(XIP_CTRL_ADDR, 8'h0d);
    chk(irq_out, 13'h0000);
    @(posedge clk);
    ack_en <= 1'b0;
    wr(XIP_CTRL_ADDR, 8'h01);
    fall(XIP_PIN_CHAN_A);
    rd(XIP_CTRL_ADDR, 8'h03);
    chk(irq_out, 13'h0000);
    wr(XIP_CTRL_ADDR, 8'h50);
    fall(XIP_PIN_CHAN_B);
    rd(XIP_CTRL_ADDR, 8'h70);
    chk(irq_out, req(1'b0, 7));
    @(posedge clk);
    ack_en <= 1'b1;
    repeat (8) @(posedge clk);
    rd(XIP_CTRL_ADDR, 8'h50);
    chk(irq_out, 13'h0000);
    @(posedge clk);
    ack_en <= 1'b0;
    $display("test edge done");
    wr(XIP_CTRL_ADDR, 8'h40);
    @(posedge clk);
    ext_low[XIP_PIN_CHAN_B] <= 1'b1;
    irq_is(req(1'b0, 7));
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      std_req <= 6'(1 << i);
      irq_is(req(1'b0, i));
    end
    wr(XIP_CTRL_ADDR, 8'hc0);
    irq_is(req(1'b1, 7));
    @(posedge clk);
    std_high <= 6'h20;
    irq_is(req(1'b1, 5));
    @(posedge clk);
    std_req <= 6'h00;
    ext_low <= 4'h0;
    irq_is(13'h0000);
    $display("test level done");
    wrap_up();
  end
endmodule
